// ==== core/phy_mode_defines.vh ====
// constants for the basic mode control register block
// assumes inclusion by bare name from core/ design files
`ifndef PHY_MODE_DEFINES_VH
`define PHY_MODE_DEFINES_VH
// ------------------------------------------------------------
// basic_mode_control field positions
// ------------------------------------------------------------
`define BMC_RESET_BIT      15
`define BMC_LOOPBACK_BIT   14
`define BMC_RATE_BIT       13
`define BMC_NEG_EN_BIT     12
`define BMC_LOW_POWER_BIT  11
`define BMC_ISOLATE_BIT    10
`define BMC_RESTART_BIT    9
`define BMC_DUPLEX_BIT     8
`define BMC_COL_TEST_BIT   7
`define BMC_RSVD_MSB       6
`define BMC_ADDR_ZERO      5'h00
`define BMC_RSVD_ZERO      7'h00
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define BMC_RATE_RST       1'b1
`define BMC_NEG_EN_RST     1'b1
`define BMC_RESTART_RST    1'b0
`define PIN_SYNC_RST       1'b0
`define OUT_RST            1'b0
`define RDATA_RST          16'h0000
// ------------------------------------------------------------
// timing (collision test), 25 MHz clock
// ------------------------------------------------------------
`define COL_ASSERT_CYC     2'd2
`define COL_CNT_ZERO       2'd0
`endif

// ==== core/phy_basic_mode_control.v ====
// basic mode control register and the mode logic it steers
// assumes a management port that presents decoded reg-0 accesses as
// one-cycle read/write strobes on the device clock; the mac side
// tx enable arrives synchronous to that clock.
`timescale 1ns/1ps
`include "phy_mode_defines.vh"

// Function
// - hardware mode: rate from rate pin
// - hardware mode: status shows active link rate
// - software, negotiation on: rate from negotiation
// - software, negotiation off: bit picks 10/100
// - hardware mode: negotiation enable from pin
// - software: enable bit selects forced or negotiated
// - low power: mac outputs driven low
// - low power: transmit pair tristated
// - low power entry clears latching status bits
// - isolate: mac outputs high-z, inputs ignored
// - isolate leaves management access working
// - isolate reset value from zero address
// - restart ignored while negotiation disabled
// - restart self-clears once negotiation begins
// - hardware mode: duplex from pin
// - hardware mode: status shows active link duplex
// - software: duplex negotiated or from bit
// - loopback: duplex bit has no effect
// - collision test off: col ignores tx enable
// - collision test on: col tracks tx enable
// - reserved low bits read zero
module phy_basic_mode_control (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [4:0]  phy_address,
    input  wire        config_source_pin,
    input  wire        rate_select_pin,
    input  wire        negotiation_select_pin,
    input  wire        duplex_select_pin,
    input  wire        reg_write,
    input  wire        reg_read,
    input  wire [15:0] reg_wdata,
    input  wire        neg_started,
    input  wire        neg_rate_100,
    input  wire        neg_full_duplex,
    input  wire        link_rate_100,
    input  wire        link_full_duplex,
    input  wire        tx_enable,
    input  wire        mac_data_valid,
    input  wire        mac_carrier,
    output reg  [15:0] reg_rdata,
    output reg         rate_100,
    output reg         full_duplex,
    output reg         neg_enable,
    output reg         neg_restart,
    output reg         low_power,
    output reg         loopback,
    output reg         tx_pair_tristate,
    output reg         latch_clear,
    output reg         mac_out_enable,
    output reg         mac_tx_accept,
    output reg         collision,
    output reg         rx_valid_out,
    output reg         carrier_out,
    output reg         status_rate_100,
    output reg         status_full_duplex
);

    // ------------------------------------------------------------
    // pin synchronisers: three stages, change counts when 2 and 3 agree
    // ------------------------------------------------------------
    localparam PIN_COUNT = 4;
    localparam PIN_CFG   = 0;
    localparam PIN_RATE  = 1;
    localparam PIN_NEG   = 2;
    localparam PIN_DPX   = 3;

    wire [PIN_COUNT-1:0] pin_raw;
    wire [PIN_COUNT-1:0] pin_level;
    wire                 cfg_level;
    wire                 rate_pin_level;
    wire                 neg_pin_level;
    wire                 dpx_pin_level;

    assign pin_raw = {duplex_select_pin, negotiation_select_pin,
                      rate_select_pin, config_source_pin};

    genvar pin_idx;
    generate
        for (pin_idx = 0; pin_idx < PIN_COUNT; pin_idx = pin_idx + 1) begin : pin_sync
            reg stage1_reg;
            reg stage2_reg;
            reg stage3_reg;
            reg level_reg;

            // a lone disagreement of stages 2 and 3 is a glitch or a
            // settling flop, so the level waits for them to agree
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    stage1_reg <= `PIN_SYNC_RST;
                    stage2_reg <= `PIN_SYNC_RST;
                    stage3_reg <= `PIN_SYNC_RST;
                    level_reg  <= `PIN_SYNC_RST;
                end else begin
                    stage1_reg <= pin_raw[pin_idx];
                    stage2_reg <= stage1_reg;
                    stage3_reg <= stage2_reg;
                    if (stage2_reg == stage3_reg)
                        level_reg <= stage3_reg;
                end
            end

            assign pin_level[pin_idx] = level_reg;
        end
    endgenerate

    assign cfg_level      = pin_level[PIN_CFG];
    assign rate_pin_level = pin_level[PIN_RATE];
    assign neg_pin_level  = pin_level[PIN_NEG];
    assign dpx_pin_level  = pin_level[PIN_DPX];

    // ------------------------------------------------------------
    // register bits
    // ------------------------------------------------------------
    reg  loop_bit_reg;
    reg  rate_bit_reg;
    reg  neg_bit_reg;
    reg  lp_bit_reg;
    reg  iso_bit_reg;
    reg  restart_bit_reg;
    reg  dpx_bit_reg;
    reg  col_bit_reg;
    reg  iso_init_reg;
    wire sw_mode;
    wire neg_en_eff;

    assign sw_mode    = cfg_level;
    assign neg_en_eff = sw_mode ? neg_bit_reg : neg_pin_level;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // the first edge after reset belongs to the isolate default load,
    // so a write landing there is dropped
    wire wr_take;
    wire wr_restart;
    wire wr_low_power_on;

    assign wr_take         = reg_write && !iso_init_reg;
    // refusal judged on the enable in force before this write
    assign wr_restart      = wr_take && sw_mode && neg_en_eff &&
                             reg_wdata[`BMC_RESTART_BIT];
    assign wr_low_power_on = wr_take && !lp_bit_reg &&
                             reg_wdata[`BMC_LOW_POWER_BIT];

    // isolate default is loaded on the first clock after reset release,
    // since the address pins may not be used as an async reset value
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            iso_init_reg    <= 1'b1;
            loop_bit_reg    <= 1'b0;
            rate_bit_reg    <= `BMC_RATE_RST;
            neg_bit_reg     <= `BMC_NEG_EN_RST;
            lp_bit_reg      <= 1'b0;
            iso_bit_reg     <= 1'b0;
            dpx_bit_reg     <= 1'b0;
            col_bit_reg     <= 1'b0;
        end else begin
            iso_init_reg <= 1'b0;
            if (iso_init_reg) begin
                iso_bit_reg <= (phy_address == `BMC_ADDR_ZERO);
            end else if (reg_write) begin
                // management writes are honoured while isolated
                loop_bit_reg <= reg_wdata[`BMC_LOOPBACK_BIT];
                rate_bit_reg <= reg_wdata[`BMC_RATE_BIT];
                neg_bit_reg  <= reg_wdata[`BMC_NEG_EN_BIT];
                lp_bit_reg   <= reg_wdata[`BMC_LOW_POWER_BIT];
                iso_bit_reg  <= reg_wdata[`BMC_ISOLATE_BIT];
                dpx_bit_reg  <= reg_wdata[`BMC_DUPLEX_BIT];
                col_bit_reg  <= reg_wdata[`BMC_COL_TEST_BIT];
            end
        end
    end

    // set wins over a start report in the same cycle, so a fresh
    // restart is never swallowed by the end of the previous one
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            restart_bit_reg <= `BMC_RESTART_RST;
        else if (wr_restart)
            restart_bit_reg <= 1'b1;
        else if (neg_started || !neg_en_eff)
            restart_bit_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // effective mode and read data
    // ------------------------------------------------------------
    wire rate_eff;
    wire dpx_eff;
    wire col_eff;
    wire [15:0] rdata_next;

    assign rate_eff = !sw_mode ? rate_pin_level :
                      (neg_en_eff ? neg_rate_100 : rate_bit_reg);
    assign dpx_eff  = loop_bit_reg ? 1'b1 :
                      (!sw_mode ? dpx_pin_level :
                      (neg_en_eff ? neg_full_duplex : dpx_bit_reg));
    // col follows tx enable one cycle later, well
    // inside 512 bit times on assert and 4 bit times (at 10M) on release
    assign col_eff  = col_bit_reg & tx_enable & !lp_bit_reg;

    assign rdata_next = {1'b0, loop_bit_reg, rate_bit_reg, neg_bit_reg,
                         lp_bit_reg, iso_bit_reg, restart_bit_reg,
                         dpx_bit_reg, col_bit_reg, `BMC_RSVD_ZERO};

    // ------------------------------------------------------------
    // read data, held until the next read
    // ------------------------------------------------------------
    // management reads stay live whatever the isolate bit says
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= `RDATA_RST;
        else if (reg_read)
            reg_rdata <= rdata_next;
    end

    // ------------------------------------------------------------
    // effective mode outputs
    // ------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rate_100         <= `OUT_RST;
            full_duplex      <= `OUT_RST;
            neg_enable       <= `OUT_RST;
            neg_restart      <= `OUT_RST;
            low_power        <= `OUT_RST;
            loopback         <= `OUT_RST;
            tx_pair_tristate <= `OUT_RST;
            latch_clear      <= `OUT_RST;
        end else begin
            rate_100         <= rate_eff;
            full_duplex      <= dpx_eff;
            neg_enable       <= neg_en_eff;
            neg_restart      <= restart_bit_reg;
            low_power        <= lp_bit_reg;
            loopback         <= loop_bit_reg;
            tx_pair_tristate <= lp_bit_reg;
            // one pulse on the write that turns low power on; a write
            // that leaves it on does not clear the latches again
            latch_clear      <= wr_low_power_on;
        end
    end

    // ------------------------------------------------------------
    // mac side gating
    // ------------------------------------------------------------
    // low power keeps drivers on but low; isolate turns them off.
    // the default-load edge counts as isolated, so no glitch of
    // enabled drivers shows before the address is known
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mac_out_enable <= `OUT_RST;
            mac_tx_accept  <= `OUT_RST;
            collision      <= `OUT_RST;
            rx_valid_out   <= `OUT_RST;
            carrier_out    <= `OUT_RST;
        end else begin
            mac_out_enable <= !iso_bit_reg && !iso_init_reg;
            mac_tx_accept  <= !iso_bit_reg && !lp_bit_reg && !iso_init_reg;
            collision      <= col_eff && !iso_bit_reg;
            rx_valid_out   <= mac_data_valid && !lp_bit_reg;
            carrier_out    <= mac_carrier && !lp_bit_reg;
        end
    end

    // ------------------------------------------------------------
    // detailed status: link values in hardware mode
    // ------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_rate_100    <= `OUT_RST;
            status_full_duplex <= `OUT_RST;
        end else if (!sw_mode) begin
            status_rate_100    <= link_rate_100;
            status_full_duplex <= link_full_duplex;
        end else begin
            status_rate_100    <= rate_eff;
            status_full_duplex <= dpx_eff;
        end
    end

endmodule

// ==== tb/neg_engine_model.sv ====
// negotiation engine stand-in: reports a begun negotiation after a restart
// assumes the block's restart output, device clock domain
`timescale 1ns/1ps
module neg_engine_model #(parameter int DELAY = 4) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic neg_restart,
    output logic      neg_started
);
    int cnt;
    // slow start on purpose, restart bit must stay set meanwhile
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            neg_started <= 1'b0;
        end else begin
            cnt <= neg_restart ? cnt + 1 : 0;
            neg_started <= neg_restart && (cnt == DELAY);
        end
    end
endmodule

// ==== tb/phy_basic_mode_control_assertions.sv ====
// checker on the mode control block ports
// assumes one clock, reset async active low
`timescale 1ns/1ps
module phy_mode_checker (
    input wire logic clock, rst_n, config_source_pin, rate_select_pin, link_rate_100,
    input wire logic neg_started, reg_write, tx_enable, rate_100, neg_enable, neg_restart,
    input wire logic low_power, tx_pair_tristate, latch_clear, mac_out_enable, mac_tx_accept,
    input wire logic collision, rx_valid_out, carrier_out, status_rate_100,
    input wire logic [15:0] reg_rdata
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // pin sync takes a few edges, so only judge a settled hardware mode
    sequence hw_settled;
        (!config_source_pin && $stable(rate_select_pin) && $stable(link_rate_100))[*6];
    endsequence
    a_hw_rate_pin: assert property (hw_settled |-> rate_100 == rate_select_pin)
        else $error("rate does not follow pin");
    a_hw_link_status: assert property (hw_settled |-> status_rate_100 == link_rate_100)
        else $error("status rate wrong");
    a_tristate_low_power: assert property (tx_pair_tristate == low_power)
        else $error("pair tristate mismatch");
    a_low_power_quiet: assert property (low_power && $past(low_power) |-> !rx_valid_out && !carrier_out)
        else $error("mac outputs active in low power");
    a_latch_pulse: assert property ($rose(latch_clear) |=> !latch_clear ##0 low_power)
        else $error("latch clear not a pulse");
    a_isolate_inputs: assert property (!mac_out_enable |-> !mac_tx_accept)
        else $error("tx accepted while isolated");
    a_restart_needs_neg: assert property ($rose(neg_restart) |-> neg_enable)
        else $error("restart without negotiation");
    a_restart_clears: assert property (neg_restart && neg_started && !reg_write |-> ##[1:2] !neg_restart)
        else $error("restart did not clear");
    a_col_cause: assert property ($rose(collision) |-> $past(tx_enable))
        else $error("collision without tx enable");
    a_col_release: assert property ($fell(tx_enable) |-> ##[0:1] !collision)
        else $error("collision held after tx enable fell");
    a_reserved_zero: assert property (reg_rdata[6:0] == 7'h00)
        else $error("reserved bits nonzero");
endmodule
bind phy_basic_mode_control phy_mode_checker phy_mode_checker_inst (.*);

// ==== tb/phy_basic_mode_control_test.sv ====
// self-checking bench for the basic mode control block
// assumes the design header on the include path; negotiation stand-in beside it
`timescale 1ns/1ps
module phy_basic_mode_control_test;
    logic clock = 0, rst_n = 0, config_source_pin = 1, rate_select_pin = 0;
    logic negotiation_select_pin = 0, duplex_select_pin = 0, reg_write = 0, reg_read = 0;
    logic neg_rate_100 = 0, neg_full_duplex = 0, link_rate_100 = 0, link_full_duplex = 0;
    logic tx_enable = 0, mac_data_valid = 1, mac_carrier = 1, neg_started;
    logic [4:0] phy_address = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic rate_100, full_duplex, neg_enable, neg_restart, low_power, loopback, tx_pair_tristate;
    logic latch_clear, mac_out_enable, mac_tx_accept, collision, rx_valid_out, carrier_out;
    logic status_rate_100, status_full_duplex;
    int error_cnt = 0, tests_run = 0, cycles = 0;
    phy_basic_mode_control phy_basic_mode_control_inst (.*);
    neg_engine_model neg_engine_model_inst (.clock(clock), .rst_n(rst_n),
        .neg_restart(neg_restart), .neg_started(neg_started));
    initial forever #20 clock = ~clock;
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // reserved bits always written as zero by the management side
    task wr(input logic [15:0] d);
        @(negedge clock); reg_write = 1; reg_wdata = d & 16'h7f80;
        @(negedge clock); reg_write = 0;
        repeat (2) @(negedge clock);
    endtask
    task rd(output logic [15:0] d);
        @(negedge clock); reg_read = 1;
        @(negedge clock); reg_read = 0;
        @(negedge clock); d = reg_rdata;
    endtask
    task t_reset;
        logic [15:0] d;
        rd(d);
        chk("reset value", d, 16'h3400);
        chk("isolated outputs", {mac_out_enable, mac_tx_accept}, 16'h0000);
        $display("reset test done");
    endtask
    task t_forced;
        logic [15:0] d;
        wr(16'h2100);
        chk("forced 100 full", {rate_100, full_duplex, neg_enable}, 16'h0006);
        chk("isolate off", {mac_out_enable, mac_tx_accept}, 16'h0003);
        wr(16'h0200);
        chk("restart ignored", {rate_100, full_duplex, neg_restart}, 16'h0000);
        rd(d);
        chk("readback", d, 16'h0000);
        $display("forced test done");
    endtask
    task t_neg;
        logic [15:0] d;
        neg_rate_100 = 1;
        wr(16'h1100);
        chk("negotiated", {rate_100, full_duplex, neg_enable}, 16'h0005);
        wr(16'h1200);
        chk("restart set", neg_restart, 16'h0001);
        repeat (10) @(negedge clock);
        rd(d);
        chk("restart cleared", d, 16'h1000);
        $display("negotiation test done");
    endtask
    task t_hw;
        config_source_pin = 0; rate_select_pin = 1; duplex_select_pin = 1; link_full_duplex = 1;
        repeat (8) @(negedge clock);
        chk("hw pins", {rate_100, full_duplex, neg_enable}, 16'h0006);
        chk("hw status", {status_rate_100, status_full_duplex}, 16'h0001);
        rate_select_pin = 0; duplex_select_pin = 0; negotiation_select_pin = 1;
        repeat (8) @(negedge clock);
        chk("hw pins change", {rate_100, full_duplex, neg_enable}, 16'h0001);
        config_source_pin = 1;
        repeat (8) @(negedge clock);
        chk("back to sw", {rate_100, neg_enable}, 16'h0003);
        $display("hardware mode test done");
    endtask
    task t_power_col;
        wr(16'h0800);
        chk("low power", {tx_pair_tristate, rx_valid_out, carrier_out}, 16'h0004);
        chk("low power bit", {low_power, loopback}, 16'h0002);
        wr(16'h4080);
        chk("loopback bit", {low_power, loopback}, 16'h0001);
        chk("loopback duplex", full_duplex, 16'h0001);
        tx_enable = 1;
        @(negedge clock); @(negedge clock);
        chk("col rise", collision, 16'h0001);
        tx_enable = 0;
        @(negedge clock); @(negedge clock);
        chk("col fall", collision, 16'h0000);
        wr(16'h0000);
        tx_enable = 1;
        repeat (3) @(negedge clock);
        chk("col off", {collision, rx_valid_out}, 16'h0001);
        tx_enable = 0;
        $display("power and collision test done");
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            test_done;
        end
    end
    initial begin
        repeat (6) @(negedge clock);
        rst_n = 1;
        repeat (6) @(negedge clock);
        t_reset;
        t_forced;
        t_neg;
        t_hw;
        t_power_col;
        test_done;
    end
endmodule
